// ==== timer_pkg.sv ====
// constants, field layouts and carriers shared by the dual timer/counter
// assumes a single 250 MHz core clock that also serves as the oscillator
package timer_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int         OSC_PER_MCYCLE = 12;  // oscillator periods per machine cycle
  localparam int         TICK_W         = 4;
  localparam logic [3:0] TICK_LAST      = 4'(OSC_PER_MCYCLE - 1);

  // ---------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam int         ADDR_W   = 8;
  localparam logic [7:0] OFS_MODE = 8'h00;  // timer_mode_control
  localparam logic [7:0] OFS_CTRL = 8'h04;  // timer_run_flag_register
  localparam logic [7:0] OFS_LO0  = 8'h08;  // count_low_unit0
  localparam logic [7:0] OFS_HI0  = 8'h0c;  // count_high_unit0
  localparam logic [7:0] OFS_LO1  = 8'h10;  // count_low_unit1
  localparam logic [7:0] OFS_HI1  = 8'h14;  // count_high_unit1

  // bit positions in timer_run_flag_register
  localparam int CTL_RUN0 = 0;
  localparam int CTL_OVF0 = 1;
  localparam int CTL_RUN1 = 2;
  localparam int CTL_OVF1 = 3;

  // reset values
  localparam logic [7:0]  MODE_RST = 8'h00;
  localparam logic [15:0] CNT_RST  = 16'h0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_13    = 2'b00,  // 8-bit high byte behind 5-bit prescaler
    MODE_16    = 2'b01,
    MODE_8R    = 2'b10,  // 8-bit auto-reload
    MODE_SPLIT = 2'b11
  } mode_e;

  typedef struct packed {
    logic  pin_qualify_enable;
    logic  count_source_select;
    mode_e mode;
  } unit_cfg_s;

  typedef struct packed {
    unit_cfg_s u1;  // upper nibble
    unit_cfg_s u0;  // lower nibble
  } mode_reg_s;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } cnt_s;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_s;

endpackage

// ==== mcycle_tick.sv ====
// machine-cycle tick generator: one pulse every twelve clocks
// assumes ref_clk is the oscillator and rst is asynchronous, active high
`timescale 1ns/1ns
module mcycle_tick (
  input  wire logic ref_clk,
  input  wire logic rst,
  output logic      tick
);

  logic [timer_pkg::TICK_W-1:0] div_q;

  // ---------------------------------------------------------------
  // divider
  // ---------------------------------------------------------------
  // twelve-clock machine cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_q <= '0;
    end else if (div_q == timer_pkg::TICK_LAST) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  assign tick = (div_q == timer_pkg::TICK_LAST);  // strobe, one clock wide

  a_tick_period: assert property (
    @(posedge ref_clk) disable iff (rst) tick |-> ##12 tick)
    else $error("machine-cycle tick not every twelve clocks");

endmodule // mcycle_tick

// ==== pin_sampler.sv ====
// count pin sampler: one sample per machine cycle, falling-edge strobe
// assumes the pin is synchronous to ref_clk and held a machine cycle per level
`timescale 1ns/1ns
module pin_sampler (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic tick,
  input  wire logic pin,
  output logic      fall_q
);

  logic samp_q;

  // ---------------------------------------------------------------
  // sampling
  // ---------------------------------------------------------------
  // high then low samples
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      samp_q <= 1'b0;  // low start: no false count after reset
      fall_q <= 1'b0;
    end else begin
      fall_q <= tick & samp_q & ~pin;
      if (tick) begin
        samp_q <= pin;
      end
    end
  end

  a_fall_detect: assert property (
    @(posedge ref_clk) disable iff (rst)
    (tick && samp_q && !pin) |=> (fall_q && !samp_q))
    else $error("falling edge on count pin not detected");

endmodule // pin_sampler

// ==== dual_timer_counter.sv ====
// dual timer/counter with four modes, registers on an AXI4-Lite slave
// assumes one clock ref_clk (oscillator rate) and async active-high rst
//
// What this block does
// - source is machine ticks or pin events
// - two-bit mode field selects operation
// - modes 0-2 same for both units, mode 3 differs
// - mode 0 uses divide-by-32 prescaler
// - mode 0 is high byte plus low five
// - wrap to zero sets overflow flag
// - run flag and qualify gate enable counting
// - starting a unit never clears counts
// - mode register nibble layout, unit 1 upper
// - mode 1 counts full sixteen bits
// - mode 2 reloads low byte from high
// - unit 1 mode 3 holds its count
// - split low byte uses unit 0 controls
// - split high byte ticks on unit 1 flags
// - unit 1 runs by mode alone when split
// - one machine tick per twelve clocks
// - pin sampled per cycle, falling edge counts
`timescale 1ns/1ns
module dual_timer_counter (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire timer_pkg::axil_req_s axil_req,
  output timer_pkg::axil_rsp_s      axil_rsp,
  input  wire logic                 count_input_unit0,
  input  wire logic                 count_input_unit1,
  input  wire logic                 ext_level_unit0,
  input  wire logic                 ext_level_unit1,
  output logic                      overflow_flag_unit0,
  output logic                      overflow_flag_unit1
);

  timer_pkg::mode_reg_s mode_q;
  timer_pkg::cnt_s      cnt0_q, cnt1_q, cnt0_d, cnt1_d;
  logic                 run0_q, run1_q, ovf0_q, ovf1_q;
  logic                 tick, fall0, fall1, split0;
  logic                 inc0, inc0_hi, inc1, set0, set1;
  logic [16:0]          step0, step1;

  // bus state
  logic                 aw_got_q, w_got_q, wstrb0_q, bvalid_q, rvalid_q;
  logic [7:0]           waddr_q, rd_byte;
  logic [31:0]          wdata_q, rdata_q;
  logic [1:0]           bresp_q, rresp_q;
  logic                 aw_hs, w_hs, ar_hs, wr_fire, wr_hit, rd_hit;
  logic                 wr_mode, wr_ctrl, wr_lo0, wr_hi0, wr_lo1, wr_hi1;

  // ---------------------------------------------------------------
  // machine tick and pin samplers
  // ---------------------------------------------------------------
  mcycle_tick u_tick (
    .ref_clk (ref_clk),
    .rst     (rst),
    .tick    (tick)
  );
  pin_sampler u_samp0 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .tick    (tick),
    .pin     (count_input_unit0),
    .fall_q  (fall0)
  );
  pin_sampler u_samp1 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .tick    (tick),
    .pin     (count_input_unit1),
    .fall_q  (fall1)
  );

  // ---------------------------------------------------------------
  // one count step for a unit: returns {overflow, hi, lo}
  // ---------------------------------------------------------------
  // mode decode, same for both units
  function automatic logic [16:0] step(timer_pkg::mode_e m, timer_pkg::cnt_s c);
    logic [4:0] pre;
    logic       cy;
    pre = 5'(c.lo[4:0] + 5'h01);
    cy  = (c.lo[4:0] == 5'h1f);
    unique case (m)
      timer_pkg::MODE_13: begin
        // upper three low bits left alone
        step = {cy & (c.hi == 8'hff), 8'(c.hi + {7'h00, cy}), c.lo[7:5], pre};
      end
      timer_pkg::MODE_16: begin
        step = {({c.hi, c.lo} == 16'hffff), 16'({c.hi, c.lo} + 16'h0001)};
      end
      timer_pkg::MODE_8R: begin
        step = (c.lo == 8'hff) ? {1'b1, c.hi, c.hi} : {1'b0, c.hi, 8'(c.lo + 8'h01)};
      end
      timer_pkg::MODE_SPLIT: begin
        step = {(c.lo == 8'hff), c.hi, 8'(c.lo + 8'h01)};
      end
    endcase
  endfunction

  // ---------------------------------------------------------------
  // count enables
  // ---------------------------------------------------------------
  assign split0 = (mode_q.u0.mode == timer_pkg::MODE_SPLIT);
  assign inc0 = run0_q & (~mode_q.u0.pin_qualify_enable | ext_level_unit0)
              & (mode_q.u0.count_source_select ? fall0 : tick);
  // split high byte: ticks only, unit 1 run flag
  assign inc0_hi = split0 & run1_q & tick;
  // unit 1 halts in its mode 3
  // run flag is taken by unit 0 while split
  assign inc1 = (split0 | run1_q)
              & (~mode_q.u1.pin_qualify_enable | ext_level_unit1)
              & (mode_q.u1.count_source_select ? fall1 : tick)
              & (mode_q.u1.mode != timer_pkg::MODE_SPLIT);
  // one step function serves both units
  assign step0 = step(mode_q.u0.mode, cnt0_q);
  assign step1 = step(mode_q.u1.mode, cnt1_q);
  assign set0 = inc0 & step0[16];
  // unit 1 loses its flag to the split high byte
  assign set1 = (inc1 & step1[16] & ~split0) | (inc0_hi & (cnt0_q.hi == 8'hff));

  // ---------------------------------------------------------------
  // next counts: software byte writes win over counting
  // ---------------------------------------------------------------
  // immediate byte writes
  always_comb begin
    cnt0_d = inc0 ? step0[15:0] : cnt0_q;
    if (inc0_hi) begin
      cnt0_d.hi = 8'(cnt0_q.hi + 8'h01);
    end
    if (wr_lo0) begin
      cnt0_d.lo = wdata_q[7:0];
    end
    if (wr_hi0) begin
      cnt0_d.hi = wdata_q[7:0];
    end
    cnt1_d = inc1 ? step1[15:0] : cnt1_q;
    if (wr_lo1) begin
      cnt1_d.lo = wdata_q[7:0];
    end
    if (wr_hi1) begin
      cnt1_d.hi = wdata_q[7:0];
    end
  end

  // count registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt0_q <= timer_pkg::CNT_RST;
      cnt1_q <= timer_pkg::CNT_RST;
    end else begin
      cnt0_q <= cnt0_d;
      cnt1_q <= cnt1_d;
    end
  end

  // ---------------------------------------------------------------
  // mode and run registers
  // ---------------------------------------------------------------
  // nibble layout held by the struct
  // run flag write leaves counts alone
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_q <= timer_pkg::MODE_RST;
      run0_q <= 1'b0;
      run1_q <= 1'b0;
    end else begin
      if (wr_mode) begin
        mode_q <= wdata_q[7:0];
      end
      if (wr_ctrl) begin
        run0_q <= wdata_q[timer_pkg::CTL_RUN0];
        run1_q <= wdata_q[timer_pkg::CTL_RUN1];
      end
    end
  end

  // overflow flags: write one to clear, a same-cycle set wins
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ovf0_q <= 1'b0;
      ovf1_q <= 1'b0;
    end else begin
      if (set0) begin
        ovf0_q <= 1'b1;
      end else if (wr_ctrl && wdata_q[timer_pkg::CTL_OVF0]) begin
        ovf0_q <= 1'b0;
      end
      if (set1) begin
        ovf1_q <= 1'b1;
      end else if (wr_ctrl && wdata_q[timer_pkg::CTL_OVF1]) begin
        ovf1_q <= 1'b0;
      end
    end
  end

  assign overflow_flag_unit0 = ovf0_q;
  assign overflow_flag_unit1 = ovf1_q;

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  assign aw_hs   = axil_req.awvalid & ~aw_got_q & ~bvalid_q;
  assign w_hs    = axil_req.wvalid & ~w_got_q & ~bvalid_q;
  assign wr_fire = aw_got_q & w_got_q & ~bvalid_q;
  assign wr_hit  = (waddr_q[7:2] <= timer_pkg::OFS_HI1[7:2]);
  assign wr_mode = wr_fire & wstrb0_q & (waddr_q[7:2] == timer_pkg::OFS_MODE[7:2]);
  assign wr_ctrl = wr_fire & wstrb0_q & (waddr_q[7:2] == timer_pkg::OFS_CTRL[7:2]);
  assign wr_lo0  = wr_fire & wstrb0_q & (waddr_q[7:2] == timer_pkg::OFS_LO0[7:2]);
  assign wr_hi0  = wr_fire & wstrb0_q & (waddr_q[7:2] == timer_pkg::OFS_HI0[7:2]);
  assign wr_lo1  = wr_fire & wstrb0_q & (waddr_q[7:2] == timer_pkg::OFS_LO1[7:2]);
  assign wr_hi1  = wr_fire & wstrb0_q & (waddr_q[7:2] == timer_pkg::OFS_HI1[7:2]);

  // address and data are caught in either order, written once both are in
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      waddr_q  <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= timer_pkg::RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_got_q <= 1'b1;
        waddr_q  <= axil_req.awaddr;
      end
      if (w_hs) begin
        w_got_q  <= 1'b1;
        wdata_q  <= axil_req.wdata;
        wstrb0_q <= axil_req.wstrb[0];  // registers sit in byte lane 0
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
      end else if (axil_req.bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  assign ar_hs  = axil_req.arvalid & ~rvalid_q;
  assign rd_hit = (axil_req.araddr[7:2] <= timer_pkg::OFS_HI1[7:2]);

  // read mux; unmapped words read zero
  always_comb begin
    unique case (axil_req.araddr[7:2])
      timer_pkg::OFS_MODE[7:2]: rd_byte = mode_q;
      timer_pkg::OFS_CTRL[7:2]: rd_byte = {4'h0, ovf1_q, run1_q, ovf0_q, run0_q};
      timer_pkg::OFS_LO0[7:2]:  rd_byte = cnt0_q.lo;
      timer_pkg::OFS_HI0[7:2]:  rd_byte = cnt0_q.hi;
      timer_pkg::OFS_LO1[7:2]:  rd_byte = cnt1_q.lo;
      timer_pkg::OFS_HI1[7:2]:  rd_byte = cnt1_q.hi;
      default:                  rd_byte = 8'h00;
    endcase
  end

  // read data is captured at the address handshake and held until taken
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= timer_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h000000, rd_byte};
      rresp_q  <= rd_hit ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
    end else if (axil_req.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  always_comb begin
    axil_rsp.awready = ~aw_got_q & ~bvalid_q;
    axil_rsp.wready  = ~w_got_q & ~bvalid_q;
    axil_rsp.bvalid  = bvalid_q;
    axil_rsp.bresp   = bresp_q;
    axil_rsp.arready = ~rvalid_q;
    axil_rsp.rvalid  = rvalid_q;
    axil_rsp.rdata   = rdata_q;
    axil_rsp.rresp   = rresp_q;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_stop_holds: assert property (
    @(posedge ref_clk) disable iff (rst)
    (!run0_q && !split0 && !wr_lo0 && !wr_hi0) |=> $stable(cnt0_q))
    else $error("unit 0 counted while stopped");
  a_unit1_halt: assert property (
    @(posedge ref_clk) disable iff (rst)
    (mode_q.u1.mode == timer_pkg::MODE_SPLIT && !wr_lo1 && !wr_hi1) |=> $stable(cnt1_q))
    else $error("unit 1 counted in its mode 3");
  a_reload_low: assert property (
    @(posedge ref_clk) disable iff (rst)
    (mode_q.u0.mode == timer_pkg::MODE_8R && inc0 && cnt0_q.lo == 8'hff
     && !wr_lo0 && !wr_hi0) |=> (cnt0_q.lo == $past(cnt0_q.hi) && ovf0_q))
    else $error("mode 2 reload or flag missing");
  a_wrap_flag: assert property (
    @(posedge ref_clk) disable iff (rst)
    (mode_q.u0.mode == timer_pkg::MODE_16 && inc0 && cnt0_q == 16'hffff
     && !wr_lo0 && !wr_hi0) |=> (cnt0_q == 16'h0000 && ovf0_q))
    else $error("sixteen-bit wrap did not set flag");
  a_prescale_carry: assert property (
    @(posedge ref_clk) disable iff (rst)
    (mode_q.u0.mode == timer_pkg::MODE_13 && inc0 && cnt0_q.lo[4:0] == 5'h1f
     && !wr_lo0 && !wr_hi0)
    |=> (cnt0_q.hi == 8'($past(cnt0_q.hi) + 8'h01) && cnt0_q.lo[4:0] == 5'h00))
    else $error("prescaler carry into high byte wrong");
  a_split_high: assert property (
    @(posedge ref_clk) disable iff (rst)
    (split0 && run1_q && tick && cnt0_q.hi == 8'hff && !wr_hi0)
    |=> (cnt0_q.hi == 8'h00 && ovf1_q))
    else $error("split high byte did not raise unit 1 flag");
  a_sw_write: assert property (
    @(posedge ref_clk) disable iff (rst)
    wr_lo1 |=> (cnt1_q.lo == $past(wdata_q[7:0])))
    else $error("count byte write not taken at once");
  a_pin_source: assert property (
    @(posedge ref_clk) disable iff (rst)
    (mode_q.u0.count_source_select && !fall0 && !split0 && !wr_lo0 && !wr_hi0)
    |=> $stable(cnt0_q))
    else $error("counter mode advanced without a pin event");

endmodule // dual_timer_counter

// ==== count_pin_model.sv ====
// far-side model: drives one count pin and one qualify level input
// assumes ref_clk is the core clock; pin idles high like a pulled-up port pin
`timescale 1ns/1ns
module count_pin_model #(
  parameter int HOLD = 12
) (
  input  wire logic       ref_clk,
  input  wire logic       start,
  input  wire logic [7:0] pulses,
  input  wire logic       level_req,
  output logic            pin,
  output logic            ext_level,
  output logic            busy
);
  logic [7:0] left_q;
  logic [7:0] hold_q;

  initial begin
    pin       = 1'b1;
    ext_level = 1'b0;
    busy      = 1'b0;
    left_q    = 8'h00;
    hold_q    = 8'h00;
  end

  // -------------------------------------------------------------
  // pulse train
  // -------------------------------------------------------------
  // each level held one machine cycle
  always @(posedge ref_clk) begin
    ext_level <= level_req;  // level follows the bench one clock later
    if (!busy && start) begin
      busy   <= 1'b1;
      left_q <= pulses;
      hold_q <= 8'h00;
    end else if (busy) begin
      if (hold_q != 8'(HOLD - 1)) begin
        hold_q <= hold_q + 8'h01;
      end else begin
        hold_q <= 8'h00;
        // a falling edge per pulse, then back high for a full hold
        if (!pin) begin
          pin <= 1'b1;
        end else if (left_q == 8'h00) begin
          busy <= 1'b0;
        end else begin
          pin    <= 1'b0;
          left_q <= left_q - 8'h01;
        end
      end
    end
  end
endmodule  // count_pin_model

// ==== tb_top.sv ====
// self-checking bench: AXI4-Lite register tasks plus pin models per unit
// assumes timer_pkg, the design files and count_pin_model are compiled first
`timescale 1ns/1ns
module tb_top;
  logic                 ref_clk = 1'b0;
  logic                 rst     = 1'b1;
  timer_pkg::axil_req_s req     = '0;
  timer_pkg::axil_rsp_s rsp;
  logic [1:0]           go      = 2'h0;
  logic [1:0]           lvl     = 2'h0;
  wire  [1:0]           pin;
  wire  [1:0]           ext;
  wire  [1:0]           busy;
  wire  [1:0]           ovf;
  int                   n_fail  = 0;
  int                   n_checks = 0;
  int                   wr_len;
  logic [1:0]           r;
  logic [7:0]           d;
  logic [1:0]           md  [3] = '{2'h0, 2'h1, 2'h2};
  logic [7:0]           li  [3] = '{8'h1c, 8'hfb, 8'hfa};
  logic [7:0]           hi  [3] = '{8'hff, 8'hff, 8'h80};
  logic [7:0]           elo [3] = '{8'h06, 8'h05, 8'h84};
  logic [7:0]           ehi [3] = '{8'h00, 8'h00, 8'h80};
  logic [7:0]           msk [3] = '{8'h1f, 8'hff, 8'hff};

  always #2 ref_clk = ~ref_clk;

  dual_timer_counter dut (.ref_clk(ref_clk), .rst(rst), .axil_req(req), .axil_rsp(rsp),
    .count_input_unit0(pin[0]), .count_input_unit1(pin[1]), .ext_level_unit0(ext[0]),
    .ext_level_unit1(ext[1]), .overflow_flag_unit0(ovf[0]), .overflow_flag_unit1(ovf[1]));
  count_pin_model pm0 (.ref_clk(ref_clk), .start(go[0]), .pulses(8'h05),
    .level_req(lvl[0]), .pin(pin[0]), .ext_level(ext[0]), .busy(busy[0]));
  count_pin_model pm1 (.ref_clk(ref_clk), .start(go[1]), .pulses(8'h05),
    .level_req(lvl[1]), .pin(pin[1]), .ext_level(ext[1]), .busy(busy[1]));

  // -------------------------------------------------------------
  // bus tasks
  // -------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // every edge a write spends is counted so windows come out exact
  task automatic clk_e;
    @(posedge ref_clk);
    wr_len++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] resp);
    logic aw, w, ta, tw;
    wr_len = 0;
    aw = 1'b0;
    w = 1'b0;
    clk_e();
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= {24'h0, v};
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    while (!(aw && w)) begin
      @(negedge ref_clk);
      ta = req.awvalid & rsp.awready;
      tw = req.wvalid & rsp.wready;
      clk_e();
      if (ta) begin
        req.awvalid <= 1'b0;
        aw = 1'b1;
      end
      if (tw) begin
        req.wvalid <= 1'b0;
        w = 1'b1;
      end
    end
    @(negedge ref_clk);
    while (rsp.bvalid !== 1'b1) begin
      clk_e();
      @(negedge ref_clk);
    end
    resp = rsp.bresp;
    clk_e();
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic [1:0] resp);
    @(posedge ref_clk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    @(negedge ref_clk);
    while (rsp.arready !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    req.arvalid <= 1'b0;
    @(negedge ref_clk);
    while (rsp.rvalid !== 1'b1) @(negedge ref_clk);
    v = rsp.rdata[7:0];
    resp = rsp.rresp;
    @(posedge ref_clk);
    req.rready <= 1'b0;
  endtask

  task automatic wt(input logic [7:0] a, input logic [7:0] v);
    wr(a, v, r);
  endtask

  task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] exp);
    rd(a, d, r);
    chk(nm, d, exp);
  endtask

  // two writes of identical latency bound a window of exactly 120 clocks, ten ticks
  task automatic win(input logic [7:0] a, input logic [7:0] on, input logic [7:0] off);
    wt(a, on);
    repeat (120 - wr_len) @(posedge ref_clk);
    wt(a, off);
  endtask

  function automatic logic [7:0] a_lo(input int u);
    return u != 0 ? timer_pkg::OFS_LO1 : timer_pkg::OFS_LO0;
  endfunction

  function automatic logic [7:0] a_hi(input int u);
    return u != 0 ? timer_pkg::OFS_HI1 : timer_pkg::OFS_HI0;
  endfunction

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // a hang is cut short far beyond the few thousand clocks the tests need
  initial begin
    #100000;
    n_fail++;
    results();
  end

  // -------------------------------------------------------------
  // tests
  // -------------------------------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rc("mode", timer_pkg::OFS_MODE, timer_pkg::MODE_RST);
    rc("ctrl", timer_pkg::OFS_CTRL, 8'h00);
    for (int u = 0; u < 2; u++) begin
      rc("lo", a_lo(u), timer_pkg::CNT_RST[7:0]);
      rc("hi", a_hi(u), timer_pkg::CNT_RST[15:8]);
    end
    wt(timer_pkg::OFS_MODE, 8'ha5);
    rc("mode", timer_pkg::OFS_MODE, 8'ha5);
    rd(8'h18, d, r);
    chk("rresp", {6'h0, r}, {6'h0, timer_pkg::RESP_SLVERR});
    wr(8'h18, 8'h00, r);
    chk("bresp", {6'h0, r}, {6'h0, timer_pkg::RESP_SLVERR});
    $display("test registers done");
    for (int u = 0; u < 2; u++) begin
      for (int i = 0; i < 3; i++) begin
        wt(timer_pkg::OFS_MODE, 8'(md[i]) << (4 * u));
        wt(a_lo(u), li[i]);
        wt(a_hi(u), hi[i]);
        win(timer_pkg::OFS_CTRL, 8'h01 << (2 * u), 8'h00);
        rd(a_lo(u), d, r);
        chk("lo", d & msk[i], elo[i]);
        rc("hi", a_hi(u), ehi[i]);
        chk("ovf", {7'h0, ovf[u]}, 8'h01);
        wt(timer_pkg::OFS_CTRL, 8'h02 << (2 * u));
        rc("ctrl", timer_pkg::OFS_CTRL, 8'h00);
      end
    end
    $display("test modes done");
    for (int u = 0; u < 2; u++) begin
      wt(timer_pkg::OFS_MODE, 8'h09 << (4 * u));
      for (int k = 0; k < 2; k++) begin
        lvl[u] <= k[0];
        wt(a_lo(u), 8'h00);
        win(timer_pkg::OFS_CTRL, 8'h01 << (2 * u), 8'h00);
        rc("gate", a_lo(u), k != 0 ? 8'h0a : 8'h00);
      end
    end
    $display("test gate done");
    for (int u = 0; u < 2; u++) begin
      wt(timer_pkg::OFS_MODE, 8'h05 << (4 * u));
      wt(a_lo(u), 8'h00);
      wt(timer_pkg::OFS_CTRL, 8'h01 << (2 * u));
      go[u] <= 1'b1;
      @(posedge ref_clk);
      go[u] <= 1'b0;
      @(negedge ref_clk);
      while (busy[u] !== 1'b0) @(negedge ref_clk);
      repeat (30) @(posedge ref_clk);
      wt(timer_pkg::OFS_CTRL, 8'h00);
      rc("pins", a_lo(u), 8'h05);
    end
    $display("test pins done");
    wt(timer_pkg::OFS_MODE, 8'h33);
    wt(timer_pkg::OFS_LO0, 8'hf8);
    wt(timer_pkg::OFS_HI0, 8'hfe);
    wt(timer_pkg::OFS_LO1, 8'hfb);
    wt(timer_pkg::OFS_HI1, 8'hff);
    win(timer_pkg::OFS_CTRL, 8'h05, 8'h00);
    rc("lo0", timer_pkg::OFS_LO0, 8'h02);
    rc("hi0", timer_pkg::OFS_HI0, 8'h08);
    rc("lo1", timer_pkg::OFS_LO1, 8'hfb);
    rc("ctrl", timer_pkg::OFS_CTRL, 8'h0a);
    wt(timer_pkg::OFS_CTRL, 8'h0a);
    win(timer_pkg::OFS_MODE, 8'h13, 8'h33);
    rc("lo1", timer_pkg::OFS_LO1, 8'h05);
    rc("hi1", timer_pkg::OFS_HI1, 8'h00);
    rc("hi0", timer_pkg::OFS_HI0, 8'h08);
    rc("ctrl", timer_pkg::OFS_CTRL, 8'h00);
    $display("test split done");
    results();
  end
endmodule  // tb_top
